// ===== verilog/hcc_map.svh
// Purpose: offsets, field positions, reset values and counts of host control flags
// Assumes: byte addresses on the register port, 32-bit words
// Notes:   included by the control flag bank only
//
// Behaviour
// - set and clear offsets, same readback
// - image valid enables config ROM answers
// - image invalid gives type error ack
// - no ROM register update when invalid
// - image valid cleared by resets, fetch error
// - bit 30 steers DMA byte swap
// - late ack enable answers ack tardy
// - each ack tardy raises tardy event
// - bits 28 to 24 read zero
// - ownership bit read-only, EEPROM loaded, one
// - link inactive disconnects node at once
// - software reset restores flags except owner, self clears
`ifndef HCC_MAP_SVH
`define HCC_MAP_SVH

// ====================================================
// register offsets
`define HCC_OFS_SET      12'h050
`define HCC_OFS_CLR      12'h054

// ====================================================
// field positions
`define HCC_B_IMG_VALID  31
`define HCC_B_SWAP_DIS   30
`define HCC_B_LATE_ACK   29
`define HCC_B_OWNER      23
`define HCC_B_ENH_ON     22
`define HCC_B_LPS        19
`define HCC_B_POSTED     18
`define HCC_B_LINK       17
`define HCC_B_SRST       16

// ====================================================
// reset values and counts
`define HCC_OWNER_RST    1'h1
`define HCC_SRST_CYCLES  8'h08

`endif

// ===== verilog/hcc_pkg.sv
// Purpose: types shared by the host control flag bank
// Assumes: nothing beyond the map header
// Notes:   no constants live here
package hcc_pkg;

	// kind of inbound asynchronous request
	typedef enum logic [1:0] {
		HCC_REQ_ROM_BLOCK = 2'h0,
		HCC_REQ_SELF      = 2'h1,
		HCC_REQ_OTHER     = 2'h2
	} hcc_req_kind_t;

	// acknowledgement chosen for a request
	typedef enum logic [1:0] {
		HCC_ACK_NONE     = 2'h0,
		HCC_ACK_COMPLETE = 2'h1,
		HCC_ACK_TYPE_ERR = 2'h2,
		HCC_ACK_TARDY    = 2'h3
	} hcc_ack_t;

	typedef struct packed {
		logic          valid;
		hcc_req_kind_t kind;
	} hcc_req_t;

	typedef struct packed {
		logic     valid;
		hcc_ack_t code;
	} hcc_rsp_t;

	// whole state of the flag bank
	typedef struct packed {
		logic        img_valid;
		logic        swap_dis;
		logic        late_ack;
		logic        owner;
		logic        enh_on;
		logic        lps;
		logic        posted;
		logic        link;
		logic        srst;
		logic [7:0]  srst_cnt;
		logic [31:0] rdata;
		logic        rvalid;
		hcc_rsp_t    rsp;
		logic        tardy_evt;
		logic        rom_update;
	} hcc_state_t;

endpackage

// ===== verilog/hcc_ctrl_flags.sv
// Purpose: host controller control flags, set/clear pair, ack policy
// Assumes: single 10 MHz clock, synchronous inputs
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/100ps
`include "hcc_map.svh"

module hcc_ctrl_flags #(
	parameter int ADDR_W = 12
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [31:0]          reg_wdata,
	output logic      [31:0]          reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic                 eeprom_load,
	input  wire logic                 eeprom_owner,
	input  wire logic                 fetch_err,
	input  wire logic                 bus_reset,
	input  wire hcc_pkg::hcc_req_t    req,
	output hcc_pkg::hcc_rsp_t         rsp,
	output logic                      tardy_evt,
	output logic                      rom_update,
	output logic                      config_rom_image_valid,
	output logic                      data_swap_disable,
	output logic                      late_ack_enable,
	output logic                      phy_enhancements_on,
	output logic                      link_power_on,
	output logic                      posted_write_on,
	output logic                      link_active,
	output logic                      software_reset_trigger
);

	// ====================================================
	// helpers

	// readback word of the flag state
	function automatic logic [31:0] hcc_word(input hcc_pkg::hcc_state_t st);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`HCC_B_IMG_VALID] = st.img_valid;
		w[`HCC_B_SWAP_DIS]  = st.swap_dis;
		w[`HCC_B_LATE_ACK]  = st.late_ack;
		w[`HCC_B_OWNER]     = st.owner;
		w[`HCC_B_ENH_ON]    = st.enh_on;
		w[`HCC_B_LPS]       = st.lps;
		w[`HCC_B_POSTED]    = st.posted;
		w[`HCC_B_LINK]      = st.link;
		w[`HCC_B_SRST]      = st.srst;
		return w;
	endfunction

	function automatic logic hcc_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		return a == ADDR_W'(ofs);
	endfunction

	hcc_pkg::hcc_state_t s_ff;
	hcc_pkg::hcc_state_t nxt_s;
	logic                wr_set;
	logic                wr_clr;

	assign wr_set = reg_wr && hcc_hit(reg_addr, `HCC_OFS_SET);
	assign wr_clr = reg_wr && hcc_hit(reg_addr, `HCC_OFS_CLR);

	// ====================================================
	// next state
	always_comb begin
		nxt_s            = s_ff;
		nxt_s.rvalid     = 1'h0;
		nxt_s.rsp        = '0;
		nxt_s.tardy_evt  = 1'h0;
		nxt_s.rom_update = 1'h0;

		if (eeprom_load) begin
			nxt_s.owner = eeprom_owner;
		end

		if (wr_set) begin
			if (reg_wdata[`HCC_B_IMG_VALID]) nxt_s.img_valid = 1'h1;
			if (reg_wdata[`HCC_B_SWAP_DIS])  nxt_s.swap_dis  = 1'h1;
			if (reg_wdata[`HCC_B_LATE_ACK])  nxt_s.late_ack  = 1'h1;
			if (reg_wdata[`HCC_B_ENH_ON])    nxt_s.enh_on    = 1'h1;
			if (reg_wdata[`HCC_B_LPS])       nxt_s.lps       = 1'h1;
			if (reg_wdata[`HCC_B_POSTED])    nxt_s.posted    = 1'h1;
			if (reg_wdata[`HCC_B_LINK])      nxt_s.link      = 1'h1;
			if (reg_wdata[`HCC_B_SRST])      nxt_s.srst      = 1'h1;
		end

		// clear path; image valid has none
		if (wr_clr) begin
			if (reg_wdata[`HCC_B_SWAP_DIS])  nxt_s.swap_dis  = 1'h0;
			if (reg_wdata[`HCC_B_LATE_ACK])  nxt_s.late_ack  = 1'h0;
			if (reg_wdata[`HCC_B_ENH_ON])    nxt_s.enh_on    = 1'h0;
			if (reg_wdata[`HCC_B_LPS])       nxt_s.lps       = 1'h0;
			if (reg_wdata[`HCC_B_POSTED])    nxt_s.posted    = 1'h0;
			if (reg_wdata[`HCC_B_LINK])      nxt_s.link      = 1'h0;
		end

		if (fetch_err) begin
			nxt_s.img_valid = 1'h0;
		end

		// ROM registers follow bus reset only when valid
		nxt_s.rom_update = bus_reset && s_ff.img_valid;

		if (req.valid && s_ff.link && !s_ff.srst) begin
			nxt_s.rsp.valid = 1'h1;
			if (s_ff.late_ack) begin
				nxt_s.rsp.code = hcc_pkg::HCC_ACK_TARDY;
			end else if (req.kind == hcc_pkg::HCC_REQ_ROM_BLOCK) begin
				nxt_s.rsp.code = s_ff.img_valid ? hcc_pkg::HCC_ACK_COMPLETE
				                                : hcc_pkg::HCC_ACK_TYPE_ERR;
			end else begin
				nxt_s.rsp.code = hcc_pkg::HCC_ACK_COMPLETE;
			end
			nxt_s.tardy_evt = s_ff.late_ack;
		end

		// soft reset runs for a fixed count
		if (s_ff.srst) begin
			if (s_ff.srst_cnt == `HCC_SRST_CYCLES - 8'h01) begin
				nxt_s.srst     = 1'h0;
				nxt_s.srst_cnt = 8'h00;
			end else begin
				nxt_s.srst     = 1'h1;
				nxt_s.srst_cnt = s_ff.srst_cnt + 8'h01;
			end
		end

		if (nxt_s.srst) begin
			nxt_s.img_valid = 1'h0;
			nxt_s.swap_dis  = 1'h0;
			nxt_s.late_ack  = 1'h0;
			nxt_s.enh_on    = 1'h0;
			nxt_s.lps       = 1'h0;
			nxt_s.posted    = 1'h0;
			nxt_s.link      = 1'h0;
		end

		// unmapped and reserved bits read zero
		if (reg_rd) begin
			nxt_s.rvalid = 1'h1;
			nxt_s.rdata  = 32'h0000_0000;
			if (hcc_hit(reg_addr, `HCC_OFS_SET) || hcc_hit(reg_addr, `HCC_OFS_CLR)) begin
				nxt_s.rdata = hcc_word(s_ff);
			end
		end
	end

	// ====================================================
	// state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_ff       <= '0;
			s_ff.owner <= `HCC_OWNER_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ====================================================
	// outputs straight from the state
	assign reg_rdata              = s_ff.rdata;
	assign reg_rvalid             = s_ff.rvalid;
	assign rsp                    = s_ff.rsp;
	assign tardy_evt              = s_ff.tardy_evt;
	assign rom_update             = s_ff.rom_update;
	assign config_rom_image_valid = s_ff.img_valid;
	assign data_swap_disable      = s_ff.swap_dis;
	assign late_ack_enable        = s_ff.late_ack;
	assign phy_enhancements_on    = s_ff.enh_on;
	assign link_power_on          = s_ff.lps;
	assign posted_write_on        = s_ff.posted;
	assign link_active            = s_ff.link;
	assign software_reset_trigger = s_ff.srst;

	// ====================================================
	// checks
	sequence s_srst_req;
		wr_set && reg_wdata[`HCC_B_SRST] && !s_ff.srst;
	endsequence

	sequence s_srst_run;
		(s_ff.srst && !s_ff.link && !s_ff.img_valid)[*8] ##1 !s_ff.srst;
	endsequence

	property p_srst_seq;
		@(posedge ref_clk) disable iff (rst)
		s_srst_req |=> s_srst_run;
	endproperty
	a_srst_seq: assert property (p_srst_seq) else $error("soft reset length wrong");

	property p_set_bit;
		@(posedge ref_clk) disable iff (rst)
		wr_set && reg_wdata[`HCC_B_LATE_ACK] && !s_ff.srst && !reg_wdata[`HCC_B_SRST]
		|=> late_ack_enable;
	endproperty
	a_set_bit: assert property (p_set_bit) else $error("set write lost");

	property p_clr_bit;
		@(posedge ref_clk) disable iff (rst)
		wr_clr && reg_wdata[`HCC_B_LINK] |=> !link_active;
	endproperty
	a_clr_bit: assert property (p_clr_bit) else $error("clear write lost");

	property p_readback;
		@(posedge ref_clk) disable iff (rst)
		reg_rd && hcc_hit(reg_addr, `HCC_OFS_CLR) |=> reg_rdata == hcc_word($past(s_ff));
	endproperty
	a_readback: assert property (p_readback) else $error("clear offset readback wrong");

	property p_rom_ok;
		@(posedge ref_clk) disable iff (rst)
		req.valid && req.kind == hcc_pkg::HCC_REQ_ROM_BLOCK && link_active && !s_ff.srst
		&& !late_ack_enable && config_rom_image_valid
		|=> rsp.valid && rsp.code == hcc_pkg::HCC_ACK_COMPLETE;
	endproperty
	a_rom_ok: assert property (p_rom_ok) else $error("rom read not answered");

	property p_rom_err;
		@(posedge ref_clk) disable iff (rst)
		req.valid && req.kind == hcc_pkg::HCC_REQ_ROM_BLOCK && link_active && !s_ff.srst
		&& !late_ack_enable && !config_rom_image_valid
		|=> rsp.valid && rsp.code == hcc_pkg::HCC_ACK_TYPE_ERR;
	endproperty
	a_rom_err: assert property (p_rom_err) else $error("missing type error ack");

	property p_no_update;
		@(posedge ref_clk) disable iff (rst)
		bus_reset && !config_rom_image_valid |=> !rom_update;
	endproperty
	a_no_update: assert property (p_no_update) else $error("rom update while invalid");

	property p_fetch_clr;
		@(posedge ref_clk) disable iff (rst)
		fetch_err |=> !config_rom_image_valid;
	endproperty
	a_fetch_clr: assert property (p_fetch_clr) else $error("fetch error kept image");

	property p_tardy;
		@(posedge ref_clk) disable iff (rst)
		req.valid && link_active && !s_ff.srst && late_ack_enable
		|=> rsp.code == hcc_pkg::HCC_ACK_TARDY && tardy_evt;
	endproperty
	a_tardy: assert property (p_tardy) else $error("tardy ack or event missing");

	property p_rsvd;
		@(posedge ref_clk) disable iff (rst)
		reg_rvalid |-> reg_rdata[28:24] == 5'h00 && reg_rdata[21:20] == 2'h0
		&& reg_rdata[15:0] == 16'h0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

	property p_owner_ro;
		@(posedge ref_clk) disable iff (rst)
		!eeprom_load |=> $stable(s_ff.owner);
	endproperty
	a_owner_ro: assert property (p_owner_ro) else $error("owner bit changed");

	property p_link_off;
		@(posedge ref_clk) disable iff (rst)
		!link_active |=> !rsp.valid;
	endproperty
	a_link_off: assert property (p_link_off) else $error("answer while link off");

	property p_rd_answer;
		@(posedge ref_clk) disable iff (rst)
		reg_rd |=> reg_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

	property p_evt_match;
		@(posedge ref_clk) disable iff (rst)
		tardy_evt |-> rsp.valid && rsp.code == hcc_pkg::HCC_ACK_TARDY;
	endproperty
	a_evt_match: assert property (p_evt_match) else $error("tardy event without tardy ack");

	property p_swap_clr;
		@(posedge ref_clk) disable iff (rst)
		wr_clr && reg_wdata[`HCC_B_SWAP_DIS] |=> !data_swap_disable;
	endproperty
	a_swap_clr: assert property (p_swap_clr) else $error("swap control not cleared");

	property p_img_kept;
		@(posedge ref_clk) disable iff (rst)
		wr_clr && config_rom_image_valid && !fetch_err && !software_reset_trigger
		|=> config_rom_image_valid;
	endproperty
	a_img_kept: assert property (p_img_kept) else $error("clear write dropped image");

	property p_rom_update;
		@(posedge ref_clk) disable iff (rst)
		bus_reset && config_rom_image_valid |=> rom_update;
	endproperty
	a_rom_update: assert property (p_rom_update) else $error("rom update missing");

endmodule // hcc_ctrl_flags

// ===== testbench/hcc_remote_node.sv
// Purpose: remote 1394 node issuing inbound requests
// Assumes: one request per send cycle
// Notes:   kind wanders while idle so stale values never pass
`timescale 1ns/100ps

// ====================
// request source
module hcc_remote_node (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               send,
	input  wire logic [1:0]         send_kind,
	output hcc_pkg::hcc_req_t       req
);
	logic [1:0] idle_kind;

	// idle kind changes every cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) idle_kind <= 2'h3;
		else idle_kind <= ~idle_kind;
	end

	// request valid only while sending
	assign req = {send, send ? send_kind : idle_kind};
endmodule // hcc_remote_node

// ===== testbench/host_controller_control_flags_tb.sv
// Purpose: self-checking bench of the control flag bank
// Assumes: inputs change 10 ns after the rising edge
// Notes:   answers come exactly one edge after a request
`timescale 1ns/100ps

module host_controller_control_flags_tb;
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [11:0]       reg_addr = 12'h000;
	logic [31:0]       reg_wdata = 32'h0;
	logic [31:0]       reg_rdata;
	logic              reg_rvalid;
	logic              eeprom_load = 1'b0;
	logic              eeprom_owner = 1'b1;
	logic              fetch_err = 1'b0;
	logic              bus_reset = 1'b0;
	logic              send = 1'b0;
	logic [1:0]        send_kind = 2'h0;
	hcc_pkg::hcc_req_t req;
	hcc_pkg::hcc_rsp_t rsp;
	logic              tardy_evt;
	logic              rom_update;
	wire  [7:0]        lvl;
	int                fail_count = 0;
	int                total_checks = 0;

	// ====================
	// clock and instances
	always #50 ref_clk = ~ref_clk;

	hcc_ctrl_flags i_hcc_ctrl_flags (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .eeprom_load(eeprom_load), .eeprom_owner(eeprom_owner),
		.fetch_err(fetch_err), .bus_reset(bus_reset), .req(req), .rsp(rsp),
		.tardy_evt(tardy_evt), .rom_update(rom_update), .config_rom_image_valid(lvl[7]),
		.data_swap_disable(lvl[6]), .late_ack_enable(lvl[5]), .phy_enhancements_on(lvl[4]),
		.link_power_on(lvl[3]), .posted_write_on(lvl[2]), .link_active(lvl[1]),
		.software_reset_trigger(lvl[0]));

	hcc_remote_node i_hcc_remote_node (.ref_clk(ref_clk), .rst(rst), .send(send),
		.send_kind(send_kind), .req(req));

	// ====================
	// shared tasks
	task tick;
		@(posedge ref_clk);
		#10;
	endtask

	task chk(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick;
		reg_wr = 1'b0;
		tick;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		reg_rd = 1'b1;
		reg_addr = a;
		tick;
		reg_rd = 1'b0;
		chk({reg_rvalid, reg_rdata}, {1'b1, exp});
		tick;
	endtask

	// exp packs valid, code, tardy event
	task ask(input logic [1:0] k, input logic [3:0] exp);
		send = 1'b1;
		send_kind = k;
		tick;
		send = 1'b0;
		chk({rsp, tardy_evt}, exp);
		tick;
	endtask

	task pulse_bus_reset(input logic exp);
		bus_reset = 1'b1;
		tick;
		bus_reset = 1'b0;
		chk(rom_update, exp);
		tick;
	endtask

	// ====================
	// scenarios
	task t_reset;
		rd(12'h050, 32'h00800000);
		rd(12'h054, 32'h00800000);
		rd(12'h058, 32'h00000000);
		$display("test reset done");
	endtask

	task t_setclr;
		wr(12'h050, 32'hFFFEFFFF);
		rd(12'h054, 32'hE0CE0000);
		chk(lvl, 8'hFE);
		wr(12'h054, 32'h7FFFFFFF);
		rd(12'h050, 32'h80800000);
		chk(lvl, 8'h80);
		$display("test set clear done");
	endtask

	task t_ack;
		wr(12'h050, 32'h00020000);
		ask(2'h0, 4'hA);
		fetch_err = 1'b1;
		tick;
		fetch_err = 1'b0;
		tick;
		chk(lvl[7], 1'b0);
		ask(2'h0, 4'hC);
		ask(2'h1, 4'hA);
		// never bus manager, no D1 entry
		wr(12'h050, 32'h20000000);
		for (int k = 0; k < 3; k++) begin
			ask(k[1:0], 4'hF);
		end
		wr(12'h054, 32'h20020000);
		ask(2'h2, 4'h0);
		$display("test ack done");
	endtask

	task t_busrst;
		pulse_bus_reset(1'b0);
		wr(12'h050, 32'h80000000);
		pulse_bus_reset(1'b1);
		$display("test bus reset done");
	endtask

	task t_srst;
		wr(12'h050, 32'h40000000);
		wr(12'h050, 32'h00010000);
		rd(12'h050, 32'h00810000);
		repeat (10) tick;
		rd(12'h050, 32'h00800000);
		$display("test soft reset done");
	endtask

	task t_owner;
		eeprom_owner = 1'b0;
		eeprom_load = 1'b1;
		tick;
		eeprom_load = 1'b0;
		tick;
		rd(12'h050, 32'h00000000);
		// owner zero, bit 22 left alone
		wr(12'h050, 32'h1F800000);
		rd(12'h054, 32'h00000000);
		$display("test owner done");
	endtask

	task t_hwrst;
		wr(12'h050, 32'h80000000);
		wr(12'h050, 32'h00020000);
		chk(lvl, 8'h82);
		rst = 1'b1;
		tick;
		rst = 1'b0;
		tick;
		rd(12'h050, 32'h00800000);
		chk(lvl, 8'h00);
		$display("test hardware reset done");
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ====================
	// main sequence and watchdog
	initial begin
		repeat (4) @(posedge ref_clk);
		#10;
		rst = 1'b0;
		tick;
		t_reset;
		t_setclr;
		t_ack;
		t_busrst;
		t_srst;
		t_owner;
		t_hwrst;
		print_verdict;
	end

	initial begin
		#200000;
		fail_count++;
		print_verdict;
	end
endmodule // host_controller_control_flags_tb
